/* rtl/gfm_pkg.sv */
// constants and carrier types for the graphics function config mirrors
package gfm_pkg;

	// =========================================================
	// register offsets (byte addresses in config space)
	localparam logic [7:0]  GMC_OFF      = 8'h52;
	localparam logic [7:0]  DEVICE_ENABLE_MIRROR_OFF    = 8'h54;
	localparam logic [7:0]  SSW_OFF      = 8'h58;
	localparam logic [7:0]  BSM_OFF      = 8'h5c;
	localparam logic [7:0]  HSW_OFF      = 8'h60;

	// =========================================================
	// reset values
	localparam logic [15:0] GMC_RST      = 16'h0030;
	localparam logic [31:0] DEVICE_ENABLE_MIRROR_RST    = 32'h000003db;
	localparam logic [31:0] SSW_RST      = 32'h00000000;
	localparam logic [31:0] BSM_RST      = 32'h07800000;
	localparam logic [15:0] HSW_RST      = 16'h0000;

	// =========================================================
	// field positions
	localparam int          GMS_LSB      = 4;
	localparam int          IVD_BIT      = 1;
	localparam int          F1EN_BIT     = 4;
	localparam int          F0EN_BIT     = 3;
	localparam int          PORT_BIT     = 1;
	localparam int          HB_BIT       = 0;
	localparam int          BSM_LSB      = 20;
	localparam int          LANE_W       = 8;
	localparam int          HALF_W       = 16;
	// device_enable_mirror bits that track the source; the rest are fixed
	localparam logic [31:0] DEVICE_ENABLE_MIRROR_LIVE   = 32'h0000001a;
	localparam logic [31:0] DEVICE_ENABLE_MIRROR_FIXED  = DEVICE_ENABLE_MIRROR_RST & ~DEVICE_ENABLE_MIRROR_LIVE;

	// =========================================================
	// pre-allocation select codes and sizes in megabytes
	localparam logic [2:0]  GMS_NONE     = 3'h0;
	localparam logic [2:0]  GMS_1MB      = 3'h1;
	localparam logic [2:0]  GMS_8MB      = 3'h3;
	localparam logic [11:0] SIZE_0MB     = 12'h000;
	localparam logic [11:0] SIZE_1MB     = 12'h001;
	localparam logic [11:0] SIZE_8MB     = 12'h008;
	localparam logic [11:0] SIZE_MAX_MB  = 12'h040;
	localparam logic [11:0] BSM_RST_MB   = BSM_RST[31:20];

	// =========================================================
	// sub-class codes
	localparam logic [7:0]  SUBCL_VGA    = 8'h00;
	localparam logic [7:0]  SUBCL_OTHER  = 8'h80;

	// =========================================================
	// carriers
	typedef struct packed {
		logic        we;
		logic [5:0]  dw;
		logic [3:0]  be;
		logic [31:0] wdata;
	} gfm_cfg_req_t;

	typedef struct packed {
		logic [2:0]  memory_preallocation_select;
		logic        vga_claim_disable;
		logic        f1en;
		logic        f0en;
		logic        port_en;
		logic        smram_lock;
		logic [11:0] low_dram_top;
	} gfm_src_t;

endpackage

/* rtl/gfm_scratch_reg.sv */
// byte-lane writable scratch register
`timescale 1ns/1ps
module gfm_scratch_reg #(
	parameter int          W   = 32,
	parameter logic [W-1:0] RST = '0
) (
	input  wire logic         clk_sys,
	input  wire logic         reset,
	input  wire logic         wr_en,
	input  wire logic [W/8-1:0] be,
	input  wire logic [W-1:0] wdata,
	output logic      [W-1:0] q
);
	logic [W-1:0] d;

	// =========================================================
	// per-lane next value
	genvar i;
	generate
		for (i = 0; i < W/8; i++) begin : g_lane
			always_comb begin
				d[i*8 +: 8] = (wr_en && be[i]) ? wdata[i*8 +: 8]
				                               : q[i*8 +: 8];
			end
		end
	endgenerate

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			q <= RST;
		end else begin
			q <= d;
		end
	end
endmodule // gfm_scratch_reg

/* rtl/gfm_mirrors.sv */
// graphics function config mirrors: register bank and decoded controls
// =========================================================
// How it works
// - select 000 means no memory; no VGA claim, sub-class 80.
// - select 001 means shared-memory mode with 1 MB frame buffer.
// - select 011 means 8 MB and is the reset value; others reserved.
// - after the SMRAM lock is set the select value is frozen.
// - VGA disable 0 (reset) with a non-zero select means claim VGA cycles, sub-class 00.
// - VGA disable 1 means no VGA claim, sub-class 80.
// - function 1 enable resets to 1; it shows or hides function 1.
// - hidden function 0 forces function 1 hidden too.
// - function 0 enable resets to 1; it shows or hides function 0.
// - express port enable resets to 1; shows or hides device 1.
// - host bridge enable always reads 1.
// - stolen base in bits 31:20, reset 078h, low bits zero.
// - stolen base is low DRAM top minus stolen size, or zero when the size exceeds the top.
// - stolen size is zero, one or eight megabytes from low DRAM top, capped at sixty-four.
// - stolen base always stays below 4 GB.
`timescale 1ns/1ps
module gfm_mirrors (
	input  wire logic                 clk_sys,
	input  wire logic                 reset,
	input  wire logic                 cfg_valid,
	input  wire gfm_pkg::gfm_cfg_req_t cfg_req,
	output logic                      cfg_ack,
	output logic               [31:0] cfg_rdata,
	input  wire gfm_pkg::gfm_src_t    src,
	output logic                      vga_claim,
	output logic                [7:0] sub_class,
	output logic                      func0_visible,
	output logic                      func1_visible,
	output logic                      port_visible,
	output logic                      host_visible,
	output logic               [11:0] stolen_base
);

	// =========================================================
	// helpers
	function automatic logic [11:0] gms_size_mb(input logic [2:0] sel);
		logic [11:0] mb;
		mb = gfm_pkg::SIZE_0MB;
		case (sel)
			gfm_pkg::GMS_1MB: mb = gfm_pkg::SIZE_1MB;
			gfm_pkg::GMS_8MB: mb = gfm_pkg::SIZE_8MB;
			default:          mb = gfm_pkg::SIZE_0MB;
		endcase
		return mb;
	endfunction

	function automatic logic is_dw(input logic [5:0] dw,
	                               input logic [7:0] off);
		return dw == off[7:2];
	endfunction

	function automatic logic [11:0] base_of(input logic [11:0] top,
	                                        input logic [11:0] mb);
		logic [11:0] sz;
		sz = (mb > gfm_pkg::SIZE_MAX_MB) ? gfm_pkg::SIZE_MAX_MB : mb;
		// 12-bit field cannot reach 4 GB; clamp instead of wrapping
		return (sz > top) ? gfm_pkg::SIZE_0MB : top - sz;
	endfunction

	// =========================================================
	// mirror state
	logic [2:0]  gms_q,  gms_d;
	logic        ivd_q,  ivd_d;
	logic        f1_q,   f1_d;
	logic        f0_q,   f0_d;
	logic        pe_q,   pe_d;
	logic        lock_q, lock_d;
	logic [11:0] base_q, base_d;

	always_comb begin
		lock_d = lock_q | src.smram_lock;
		// the lock only clears on reset, so the freeze is one-way
		gms_d  = lock_q ? gms_q : src.memory_preallocation_select;
		ivd_d  = src.vga_claim_disable;
		f1_d   = src.f1en;
		f0_d   = src.f0en;
		pe_d   = src.port_en;
		base_d = base_of(src.low_dram_top, gms_size_mb(gms_q));
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			gms_q  <= gfm_pkg::GMC_RST[gfm_pkg::GMS_LSB +: 3];
			ivd_q  <= gfm_pkg::GMC_RST[gfm_pkg::IVD_BIT];
			f1_q   <= gfm_pkg::DEVICE_ENABLE_MIRROR_RST[gfm_pkg::F1EN_BIT];
			f0_q   <= gfm_pkg::DEVICE_ENABLE_MIRROR_RST[gfm_pkg::F0EN_BIT];
			pe_q   <= gfm_pkg::DEVICE_ENABLE_MIRROR_RST[gfm_pkg::PORT_BIT];
			lock_q <= 1'b0;
			base_q <= gfm_pkg::BSM_RST_MB;
		end else begin
			gms_q  <= gms_d;
			ivd_q  <= ivd_d;
			f1_q   <= f1_d;
			f0_q   <= f0_d;
			pe_q   <= pe_d;
			lock_q <= lock_d;
			base_q <= base_d;
		end
	end

	// =========================================================
	// decoded controls
	always_comb begin
		vga_claim     = (gms_q != gfm_pkg::GMS_NONE) && !ivd_q;
		sub_class     = vga_claim ? gfm_pkg::SUBCL_VGA
		                          : gfm_pkg::SUBCL_OTHER;
		func0_visible = f0_q;
		func1_visible = f0_q && f1_q;
		port_visible  = pe_q;
		host_visible  = 1'b1;
		stolen_base   = base_q;
	end

	// =========================================================
	// register images
	logic [15:0] gmc_img;
	logic [31:0] device_enable_mirror_img;
	logic [31:0] bsm_img;
	logic [31:0] ssw_q;
	logic [15:0] hsw_q;

	always_comb begin
		gmc_img = '0;
		gmc_img[gfm_pkg::GMS_LSB +: 3] = gms_q;
		gmc_img[gfm_pkg::IVD_BIT]      = ivd_q;
		device_enable_mirror_img = gfm_pkg::DEVICE_ENABLE_MIRROR_FIXED;
		device_enable_mirror_img[gfm_pkg::F1EN_BIT] = f1_q;
		device_enable_mirror_img[gfm_pkg::F0EN_BIT] = f0_q;
		device_enable_mirror_img[gfm_pkg::PORT_BIT] = pe_q;
		bsm_img = {base_q, 20'h00000};
	end

	// =========================================================
	// scratch registers
	logic ssw_we;
	logic hsw_we;

	always_comb begin
		ssw_we = cfg_valid && cfg_req.we && is_dw(cfg_req.dw, gfm_pkg::SSW_OFF);
		hsw_we = cfg_valid && cfg_req.we && is_dw(cfg_req.dw, gfm_pkg::HSW_OFF);
	end

	gfm_scratch_reg #(
		.W   (32),
		.RST (gfm_pkg::SSW_RST)
	) u_ssw (
		.clk_sys (clk_sys),
		.reset   (reset),
		.wr_en   (ssw_we),
		.be      (cfg_req.be),
		.wdata   (cfg_req.wdata),
		.q       (ssw_q)
	);

	// hardware scratch sits in the low half of its dword
	gfm_scratch_reg #(
		.W   (16),
		.RST (gfm_pkg::HSW_RST)
	) u_hsw (
		.clk_sys (clk_sys),
		.reset   (reset),
		.wr_en   (hsw_we),
		.be      (cfg_req.be[1:0]),
		.wdata   (cfg_req.wdata[15:0]),
		.q       (hsw_q)
	);

	// =========================================================
	// config read path: one cycle from request to answer
	logic        ack_q, ack_d;
	logic [31:0] rd_q,  rd_d;

	always_comb begin
		ack_d = cfg_valid;
		rd_d  = '0;
		if (!cfg_valid || cfg_req.we) begin
			rd_d = '0;
		end else if (is_dw(cfg_req.dw, gfm_pkg::GMC_OFF)) begin
			// mirror occupies the upper half of its dword
			rd_d = {gmc_img, 16'h0000};
		end else if (is_dw(cfg_req.dw, gfm_pkg::DEVICE_ENABLE_MIRROR_OFF)) begin
			rd_d = device_enable_mirror_img;
		end else if (is_dw(cfg_req.dw, gfm_pkg::SSW_OFF)) begin
			rd_d = ssw_q;
		end else if (is_dw(cfg_req.dw, gfm_pkg::BSM_OFF)) begin
			rd_d = bsm_img;
		end else if (is_dw(cfg_req.dw, gfm_pkg::HSW_OFF)) begin
			rd_d = {16'h0000, hsw_q};
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			ack_q <= 1'b0;
			rd_q  <= '0;
		end else begin
			ack_q <= ack_d;
			rd_q  <= rd_d;
		end
	end

	always_comb begin
		cfg_ack   = ack_q;
		cfg_rdata = rd_q;
	end

	// =========================================================
	// checks
	logic rd_device_enable_mirror_q;
	logic rd_bsm_q;

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			rd_device_enable_mirror_q <= 1'b0;
			rd_bsm_q   <= 1'b0;
		end else begin
			rd_device_enable_mirror_q <= cfg_valid && !cfg_req.we
			              && is_dw(cfg_req.dw, gfm_pkg::DEVICE_ENABLE_MIRROR_OFF);
			rd_bsm_q   <= cfg_valid && !cfg_req.we
			              && is_dw(cfg_req.dw, gfm_pkg::BSM_OFF);
		end
	end

	sequence s_locked;
		lock_q ##1 lock_q;
	endsequence

	AST_NONE_NO_CLAIM: assert property (@(posedge clk_sys) disable iff (reset)
		gms_q == gfm_pkg::GMS_NONE |-> !vga_claim && sub_class == 8'h80)
		else $error("no pre-allocation yet VGA claimed");

	AST_SIZE_1MB: assert property (@(posedge clk_sys) disable iff (reset)
		gms_q == 3'h1 && src.low_dram_top != 12'h000
		|=> base_q == $past(src.low_dram_top) - 12'h001)
		else $error("select 001 did not steal one megabyte");

	AST_RESET_8MB: assert property (@(posedge clk_sys) disable iff (reset)
		$fell(reset) |-> gms_q == 3'h3 && base_q == 12'h078)
		else $error("wrong mirror reset values");

	AST_LOCK_FREEZE: assert property (@(posedge clk_sys) disable iff (reset)
		s_locked |-> $stable(gms_q))
		else $error("select changed after lock");

	AST_CLAIM_VGA: assert property (@(posedge clk_sys) disable iff (reset)
		!ivd_q && gms_q != 3'h0 |-> vga_claim && sub_class == 8'h00)
		else $error("VGA not claimed while enabled");

	AST_NO_CLAIM_VGA: assert property (@(posedge clk_sys) disable iff (reset)
		ivd_q |-> !vga_claim && sub_class == 8'h80)
		else $error("VGA claimed while disabled");

	AST_FUNC1_HIDE: assert property (@(posedge clk_sys) disable iff (reset)
		!src.f0en ##1 1'b1 |-> !func1_visible && !func0_visible)
		else $error("function 1 visible with function 0 hidden");

	AST_FUNC_TRACK: assert property (@(posedge clk_sys) disable iff (reset)
		1'b1 |=> func0_visible == $past(src.f0en)
		         && port_visible == $past(src.port_en)
		         && func1_visible == ($past(src.f0en) && $past(src.f1en)))
		else $error("mirror does not follow source");

	AST_HOST_ONE: assert property (@(posedge clk_sys) disable iff (reset)
		rd_device_enable_mirror_q |-> cfg_ack && cfg_rdata[0] && cfg_rdata[9:5] == 5'h1e)
		else $error("host bridge enable read as zero");

	AST_BSM_LOW: assert property (@(posedge clk_sys) disable iff (reset)
		rd_bsm_q |-> cfg_rdata[19:0] == 20'h00000
		             && cfg_rdata[31:20] == $past(base_q))
		else $error("stolen base read wrong");

	AST_BSM_CALC: assert property (@(posedge clk_sys) disable iff (reset)
		$past(gms_size_mb(gms_q)) <= $past(src.low_dram_top) && !$fell(reset)
		|-> base_q == $past(src.low_dram_top) - $past(gms_size_mb(gms_q)))
		else $error("stolen base not top minus size");

	AST_BSM_RANGE: assert property (@(posedge clk_sys) disable iff (reset)
		1'b1 |=> base_q <= $past(src.low_dram_top) || base_q == 12'h078)
		else $error("stolen base above low DRAM top");

endmodule // gfm_mirrors

/* verification/gfm_mirrors_bench.sv */
// self-checking bench for the graphics function config mirrors
`timescale 1ns/1ps
module gfm_mirrors_bench;
	logic                  clk_sys;
	logic                  reset;
	logic                  cfg_valid;
	gfm_pkg::gfm_cfg_req_t cfg_req;
	logic                  cfg_ack;
	logic           [31:0] cfg_rdata;
	gfm_pkg::gfm_src_t     src;
	gfm_pkg::gfm_src_t     s;
	logic                  vga_claim;
	logic            [7:0] sub_class;
	logic                  func0_visible;
	logic                  func1_visible;
	logic                  port_visible;
	logic                  host_visible;
	logic           [11:0] stolen_base;
	logic           [31:0] rd;
	logic           [31:0] ssw_m;
	logic           [31:0] hsw_m;
	logic           [31:0] m;
	logic            [3:0] be;
	logic            [2:0] gms_m;
	logic                  lock_m;
	logic            [5:0] unmapped [4] = '{6'h00, 6'h13, 6'h19, 6'h3f};
	int                    num_errors;
	int                    tests_run;
	int                    seed;
	int                    i;

	gfm_mirrors i_gfm_mirrors (
		.clk_sys       (clk_sys),
		.reset         (reset),
		.cfg_valid     (cfg_valid),
		.cfg_req       (cfg_req),
		.cfg_ack       (cfg_ack),
		.cfg_rdata     (cfg_rdata),
		.src           (src),
		.vga_claim     (vga_claim),
		.sub_class     (sub_class),
		.func0_visible (func0_visible),
		.func1_visible (func1_visible),
		.port_visible  (port_visible),
		.host_visible  (host_visible),
		.stolen_base   (stolen_base)
	);

	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end

	// =========================================================
	// helpers
	task automatic chk(input string name, input logic [31:0] exp,
		input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic give_verdict;
		$display("errors %0d, checks %0d", num_errors, tests_run);
		if (num_errors == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] wd, input logic [3:0] en);
		for (int k = 0; k < 4; k++)
			if (en[k])
				old[8*k +: 8] = wd[8*k +: 8];
		return old;
	endfunction

	// valid is a one-cycle pulse; ack rises on the edge that takes it and is checked at the next negedge
	task automatic cfg(input logic we, input logic [5:0] dw,
		input logic [3:0] ben, input logic [31:0] wd,
		output logic [31:0] rdo);
		@(posedge clk_sys);
		cfg_valid <= 1'b1;
		cfg_req   <= '{we: we, dw: dw, be: ben, wdata: wd};
		@(posedge clk_sys);
		cfg_valid <= 1'b0;
		@(negedge clk_sys);
		chk("cfg_ack", 32'h1, cfg_ack);
		rdo = cfg_rdata;
		if (we)
			chk("write_rdata", 32'h0, cfg_rdata);
	endtask

	task automatic apply(input gfm_pkg::gfm_src_t ns);
		@(posedge clk_sys);
		src <= ns;
		if (!lock_m)
			gms_m = ns.memory_preallocation_select;
		lock_m = lock_m | ns.smram_lock;
	endtask

	task automatic do_reset;
		@(posedge clk_sys);
		reset <= 1'b1;
		repeat (5) @(posedge clk_sys);
		@(negedge clk_sys);
		chk("rst_vga_claim", 32'h1, vga_claim);
		chk("rst_sub_class", 32'h0, sub_class);
		chk("rst_visible", 32'h7, {func0_visible, func1_visible,
			port_visible});
		chk("rst_stolen_base", 32'h078, stolen_base);
		@(posedge clk_sys);
		reset <= 1'b0;
		lock_m = 1'b0;
		gms_m  = src.memory_preallocation_select;
		ssw_m  = 32'h0;
		hsw_m  = 32'h0;
	endtask

	// settle, then compare every output and every mirror read
	task automatic check_all;
		logic        claim;
		logic [11:0] sz;
		logic [11:0] base;
		repeat (3) @(posedge clk_sys);
		@(negedge clk_sys);
		claim = (gms_m != 3'h0) && !src.vga_claim_disable;
		case (gms_m)
			3'h1:    sz = 12'h001;
			3'h3:    sz = 12'h008;
			default: sz = 12'h000;
		endcase
		base = (src.low_dram_top >= sz) ? src.low_dram_top - sz : 12'h0;
		chk("vga_claim", claim, vga_claim);
		chk("sub_class", claim ? 8'h00 : 8'h80, sub_class);
		chk("func0_visible", src.f0en, func0_visible);
		chk("func1_visible", src.f0en & src.f1en, func1_visible);
		chk("port_visible", src.port_en, port_visible);
		chk("host_visible", 32'h1, host_visible);
		chk("stolen_base", base, stolen_base);
		cfg(1'b0, 6'h14, 4'hf, 32'h0, rd);
		chk("graphics_control", {9'h0, gms_m, 2'h0, src.vga_claim_disable, 1'b0,
			16'h0}, rd);
		cfg(1'b0, 6'h15, 4'hf, 32'h0, rd);
		chk("device_enable", 32'h3c1 | {src.f1en, src.f0en, 1'b0,
			src.port_en, 1'b0}, rd);
		cfg(1'b0, 6'h17, 4'hf, 32'h0, rd);
		chk("stolen_memory_base", {base, 20'h0}, rd);
	endtask

	// =========================================================
	// main sequence
	initial begin
		seed       = 97;
		num_errors = 0;
		tests_run  = 0;
		reset      = 1'b1;
		cfg_valid  = 1'b0;
		cfg_req    = '0;
		src        = '{3'h3, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 12'h080};
		s          = src;
		do_reset;
		cfg(1'b0, 6'h16, 4'hf, 32'h0, rd);
		chk("software_scratch", 32'h0, rd);
		cfg(1'b0, 6'h18, 4'hf, 32'h0, rd);
		chk("hardware_scratch", 32'h0, rd);
		check_all;
		for (i = 0; i < 4; i++) begin
			cfg(1'b0, unmapped[i], 4'hf, 32'h0, rd);
			chk("unmapped", 32'h0, rd);
		end
		cfg(1'b1, 6'h14, 4'hf, 32'hffffffff, rd);
		cfg(1'b1, 6'h15, 4'hf, 32'h0, rd);
		cfg(1'b1, 6'h17, 4'hf, 32'hffffffff, rd);
		check_all;
		for (i = 0; i < 10; i++) begin
			m  = $random(seed);
			be = $random(seed);
			cfg(1'b1, 6'h16, be, m, rd);
			ssw_m = merge(ssw_m, m, be);
			cfg(1'b1, 6'h18, be, ~m, rd);
			hsw_m = merge(hsw_m, ~m, {2'b00, be[1:0]});
			cfg(1'b0, 6'h16, 4'hf, 32'h0, rd);
			chk("software_scratch", ssw_m, rd);
			cfg(1'b0, 6'h18, 4'hf, 32'h0, rd);
			chk("hardware_scratch", hsw_m, rd);
		end
		// every select code with both vga settings; small tops underflow
		for (i = 0; i < 16; i++) begin
			m = $random(seed);
			s.memory_preallocation_select          = i[2:0];
			s.vga_claim_disable          = i[3];
			s.f1en         = m[0];
			// memory is only pre-allocated with function 0 enabled
			s.f0en         = m[1] | (i[2:0] != 3'h0);
			s.port_en      = m[2];
			s.smram_lock   = 1'b0;
			s.low_dram_top = i[2] ? m[31:20] : 12'(i);
			apply(s);
			check_all;
		end
		s.smram_lock = 1'b1;
		apply(s);
		check_all;
		s.memory_preallocation_select = 3'h1;
		apply(s);
		check_all;
		s.smram_lock = 1'b0;
		apply(s);
		check_all;
		do_reset;
		check_all;
		give_verdict;
	end

	initial begin
		#(100 * 8000);
		num_errors++;
		give_verdict;
	end
endmodule // gfm_mirrors_bench
